// ### common/mrs_pkg.sv
/*
  Shared constants for the monitor readback and status port: frame layouts,
  status bit positions, converter scaling and the serial bus address width.
  Assumes a single 100 MHz system clock domain.
*/
package mrs_pkg;
  localparam int unsigned DATA_W = 12;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned CODE_STEPS = 4096;
  // Full scale in microvolts for voltage, nanovolts for the current sense
  localparam int unsigned VOLT_FS_NARROW_UV = 6650000;
  localparam int unsigned VOLT_FS_WIDE_UV = 26350000;
  localparam int unsigned AMP_FS_SENSE_NV = 105840000;
  // Status byte bit positions
  localparam int unsigned ST_CONV_OC_NOW = 0;
  localparam int unsigned ST_CONV_ALERT = 1;
  localparam int unsigned ST_ANALOG_TRIP = 2;
  localparam int unsigned ST_SWAP_FAIL = 3;
  localparam int unsigned ST_OFF_NOW = 4;
  localparam int unsigned ST_OFF_ALERT = 5;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int unsigned OC_HISTORY = 3;
  localparam logic [7:0] NIBBLE_ZERO = 8'h00;
  // Frame lengths in bytes
  localparam logic [1:0] LEN_COMBINED = 2'h3;
  localparam logic [1:0] LEN_SINGLE = 2'h2;
  localparam logic [1:0] LEN_STATUS = 2'h1;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h40;
endpackage : mrs_pkg

// ### verilog/mrs_sync.sv
/*
  Two flip-flop level synchroniser for pins entering the system clock domain.
  Assumes the input is a level that holds for several clock periods.
*/
`timescale 1ns/1ps
module mrs_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      // Idle-high level, so no false edge on bus or enable pins after reset
      meta_reg <= '1;
      o_sync <= '1;
    end
    else
    begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule : mrs_sync

// ### verilog/mrs_readback_port.sv
/*
  Serial two-wire read side of a power monitor: address match, read frames of
  conversion data or the status byte, and the sticky alert flags.
  Assumes the conversion engine supplies 12-bit codes with valid strobes, and
  that the bus master keeps the protocol (acks, nack on last byte, stop).
*/
//
// Contract
// - Combined mode sends volt[11:4], amp[11:4], then volt[3:0] and amp[3:0].
// - Voltage mode sends volt[11:4], then volt[3:0] over four zero bits.
// - Current mode sends amp[11:4], then amp[3:0] over four zero bits.
// - Master starts, sends address with read bit; device acks before data.
// - Voltage step is full scale over 4096, 6.65 V or 26.35 V.
// - Current step is 105.84 mV sense over 4096, divided by sense resistance.
// - Status read: address with read bit, ack, one status byte returned.
// - Status bit 0 set while last three current conversions exceed threshold.
// - Status bit 1 latches on converter overcurrent alert until clear.
// - Status bit 2 shows analog trip off; sticky copy on latching variants, here only while the swap failure alert is enabled.
// - Status bit 3 latches on hot swap failure until clear.
// - Status bit 4 reads 1 while enable pin low or software off set.
// - Status bit 5 latches on enable pin or software-off alert until clear.
// - Clear control resets status bits 1, 3 and 5 only; here bit 2 also clears while it mirrors the swap failure latch.
// - Status-read mode returns the status byte instead of conversion data.
// - Clear self-returns to zero; flags may set again at once.
// - Continuous mode read before first conversion acks and returns zeros.
// - Single-conversion mode nacks reads until done; request bit self-clears.
`timescale 1ns/1ps
module mrs_readback_port #(
  parameter bit LATCHING_VARIANT = 1'b1
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe,
  input wire logic [6:0] i_dev_addr,
  input wire logic i_volt_continuous,
  input wire logic i_amp_continuous,
  input wire logic i_volt_once,
  input wire logic i_amp_once,
  input wire logic i_status_read,
  input wire logic i_divider_range_select,
  input wire logic [mrs_pkg::DATA_W-1:0] i_volt_code,
  input wire logic i_volt_valid,
  input wire logic [mrs_pkg::DATA_W-1:0] i_amp_code,
  input wire logic i_amp_valid,
  input wire logic [7:0] i_amp_threshold,
  input wire logic i_conv_alert_enable,
  input wire logic i_analog_trip_off,
  input wire logic i_swap_fail_event,
  input wire logic i_swap_fail_alert_enable,
  input wire logic i_off_alert_enable,
  input wire logic i_enable_pin,
  input wire logic i_software_off,
  input wire logic i_clear,
  output logic o_clear_done,
  output logic o_once_done,
  output logic [7:0] o_alert_status,
  output logic [mrs_pkg::DATA_W+7:0] o_volt_step_uv_x4096
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_ADDR = 6'h02, ST_AACK = 6'h04,
    ST_SEND = 6'h08, ST_MACK = 6'h10, ST_SKIP = 6'h20
  } mrs_state_t;

  logic scl_s, sda_s, en_s, scl_d_reg, sda_d_reg;
  mrs_sync #(.WIDTH(3)) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_async({i_scl, i_sda, i_enable_pin}),
    .o_sync({scl_s, sda_s, en_s})
  );

  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_c = scl_s & sda_d_reg & ~sda_s;
  wire stop_c = scl_s & ~sda_d_reg & sda_s;

  mrs_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [1:0] byte_idx_reg;
  logic [1:0] len_reg;
  logic [23:0] frame_reg;
  logic volt_seen_reg, amp_seen_reg, once_pend_reg, once_req_d_reg;
  logic [mrs_pkg::OC_HISTORY-1:0] oc_hist_reg;
  logic conv_alert_reg, swap_fail_latched_reg, off_alert_reg;
  logic off_now_d_reg, clear_d_reg;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // Data availability tracking for continuous and single-shot modes
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      volt_seen_reg <= 1'b0;
      amp_seen_reg <= 1'b0;
      once_req_d_reg <= 1'b0;
      once_pend_reg <= 1'b0;
    end
    else
    begin
      if (i_volt_valid)
        volt_seen_reg <= 1'b1;
      if (i_amp_valid)
        amp_seen_reg <= 1'b1;
      once_req_d_reg <= i_volt_once | i_amp_once;
      // A request level still held must not re-arm once its conversion lands
      if ((i_volt_once | i_amp_once) & ~once_req_d_reg)
        once_pend_reg <= 1'b1;
      else if (i_volt_valid | i_amp_valid)
        once_pend_reg <= 1'b0;
    end
  end
  assign o_once_done = ~once_pend_reg;

  // Overcurrent history over the most recent current conversions
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      oc_hist_reg <= '0;
    else if (i_amp_valid)
      oc_hist_reg <= {oc_hist_reg[mrs_pkg::OC_HISTORY-2:0],
                      i_amp_code[11:4] > i_amp_threshold};
  end

  wire off_now = ~en_s | i_software_off;
  wire conv_set = i_conv_alert_enable & (&oc_hist_reg);
  wire swap_set = i_swap_fail_event & i_swap_fail_alert_enable;
  wire off_set = i_off_alert_enable & off_now & ~off_now_d_reg;
  wire clr = i_clear & ~clear_d_reg;

  // Sticky flags; a set in the clear cycle wins so no event is lost
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      conv_alert_reg <= 1'b0;
      swap_fail_latched_reg <= 1'b0;
      off_alert_reg <= 1'b0;
      off_now_d_reg <= 1'b0;
      clear_d_reg <= 1'b0;
    end
    else
    begin
      off_now_d_reg <= off_now;
      clear_d_reg <= i_clear;
      conv_alert_reg <= conv_set | (conv_alert_reg & ~clr);
      swap_fail_latched_reg <= swap_set | (swap_fail_latched_reg & ~clr);
      off_alert_reg <= off_set | (off_alert_reg & ~clr);
    end
  end
  assign o_clear_done = clear_d_reg;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      o_alert_status <= mrs_pkg::STATUS_RESET;
    else
    begin
      o_alert_status <= mrs_pkg::STATUS_RESET;
      o_alert_status[mrs_pkg::ST_CONV_OC_NOW] <= &oc_hist_reg;
      o_alert_status[mrs_pkg::ST_CONV_ALERT] <= conv_alert_reg;
      o_alert_status[mrs_pkg::ST_ANALOG_TRIP] <= LATCHING_VARIANT ?
        (i_swap_fail_alert_enable ? swap_fail_latched_reg : i_analog_trip_off)
        : i_analog_trip_off;
      o_alert_status[mrs_pkg::ST_SWAP_FAIL] <= swap_fail_latched_reg;
      o_alert_status[mrs_pkg::ST_OFF_NOW] <= off_now;
      o_alert_status[mrs_pkg::ST_OFF_ALERT] <= off_alert_reg;
    end
  end

  // Reading in 256 uV units; the product needs 37 bits, so 64 are used, as 32 would wrap
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      o_volt_step_uv_x4096 <= '0;
    else
      o_volt_step_uv_x4096 <= 20'((64'(i_volt_code) *
        64'(i_divider_range_select ? mrs_pkg::VOLT_FS_NARROW_UV
                                   : mrs_pkg::VOLT_FS_WIDE_UV)) >> 20);
  end

  // Frame assembly; zeros returned before first conversion
  function automatic logic [23:0] build_frame(input logic [11:0] v, input logic [11:0] a,
                                              input logic vc, input logic ac);
    begin
      if (vc & ac)
        build_frame = {v[11:4], a[11:4], v[3:0], a[3:0]};
      else if (ac)
        build_frame = {a[11:4], a[3:0], 4'h0, 8'h00};
      else
        build_frame = {v[11:4], v[3:0], 4'h0, 8'h00};
    end
  endfunction : build_frame

  wire [11:0] v_data = volt_seen_reg ? i_volt_code : 12'h000;
  wire [11:0] a_data = amp_seen_reg ? i_amp_code : 12'h000;
  wire vc = i_volt_continuous | i_volt_once;
  wire ac = i_amp_continuous | i_amp_once;
  // Note: amp step is code * 105.84 mV / 4096, divided by Rsense off chip

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      byte_idx_reg <= 2'h0;
      frame_reg <= 24'h000000;
      len_reg <= 2'h0;
      o_sda_oe <= 1'b0;
    end
    else if (start_c)
    begin
      state_reg <= ST_ADDR;
      bit_cnt_reg <= 4'h0;
      o_sda_oe <= 1'b0;
    end
    else if (stop_c)
    begin
      state_reg <= ST_IDLE;
      o_sda_oe <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
          o_sda_oe <= 1'b0;
        ST_ADDR:
        begin
          if (scl_rise)
          begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          if (scl_fall && bit_cnt_reg == 4'h8)
          begin
            // Only reads are served; a busy single shot is acknowledged only in status-read mode
            if (shift_reg[7:1] == i_dev_addr && shift_reg[0] &&
                (i_status_read || !once_pend_reg))
            begin
              o_sda_oe <= 1'b1;
              state_reg <= ST_AACK;
              byte_idx_reg <= 2'h0;
              len_reg <= i_status_read ? mrs_pkg::LEN_STATUS
                       : (vc & ac) ? mrs_pkg::LEN_COMBINED : mrs_pkg::LEN_SINGLE;
              frame_reg <= i_status_read ? {o_alert_status, 16'h0000}
                                         : build_frame(v_data, a_data, vc, ac);
            end
            else
              state_reg <= ST_SKIP;
          end
        end
        ST_AACK, ST_MACK:
        begin
          if (scl_fall && byte_idx_reg == len_reg)
          begin
            // Frame done: let go of SDA so a master that acked can still stop
            o_sda_oe <= 1'b0;
            state_reg <= ST_SKIP;
          end
          else if (scl_fall)
          begin
            o_sda_oe <= ~frame_reg[23];
            shift_reg <= frame_reg[23:16];
            frame_reg <= {frame_reg[15:0], 8'h00};
            bit_cnt_reg <= 4'h1;
            state_reg <= ST_SEND;
          end
          if (state_reg == ST_MACK && scl_rise && sda_s)
            state_reg <= ST_SKIP;
        end
        ST_SEND:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_reg == 4'h8)
            begin
              o_sda_oe <= 1'b0;
              byte_idx_reg <= byte_idx_reg + 2'h1;
              state_reg <= ST_MACK;
            end
            else
            begin
              o_sda_oe <= ~shift_reg[6];
              shift_reg <= {shift_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        ST_SKIP:
          o_sda_oe <= 1'b0;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule : mrs_readback_port

// ### test/mrs_port_asserts.sv
/*
  Checker for the readback port: status flags, clear and SDA drive.
  Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
module mrs_port_asserts (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic o_sda_oe,
  input wire logic i_enable_pin,
  input wire logic i_software_off,
  input wire logic i_clear,
  input wire logic i_swap_fail_event,
  input wire logic i_amp_valid,
  input wire logic i_conv_alert_enable,
  input wire logic i_off_alert_enable,
  input wire logic o_clear_done,
  input wire logic [7:0] o_alert_status
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  sequence s_sw_off;
    i_software_off [*4];
  endsequence
  sequence s_pin_low;
    !i_enable_pin [*6];
  endsequence
  a_top_bits_zero: assert property (o_alert_status[7:6] == 2'h0)
    else $error("status top bits not zero");
  a_soft_off_shown: assert property (s_sw_off |-> o_alert_status[4])
    else $error("software off not shown");
  a_pin_off_shown: assert property (s_pin_low |-> o_alert_status[4])
    else $error("enable pin low not shown");
  a_on_not_shown: assert property (
    (i_enable_pin && !i_software_off)[*6] |-> !o_alert_status[4])
    else $error("off status without cause");
  a_swap_sets: assert property (i_swap_fail_event |-> ##[1:3] o_alert_status[3])
    else $error("swap failure not latched");
  a_sticky_hold: assert property (
    (|($past(o_alert_status) & ~o_alert_status & 8'h2A))
    |-> $past(i_clear) || $past(i_clear, 2) || $past(i_clear, 3))
    else $error("sticky bit dropped without clear");
  // Sources are held off so that the flags cannot set again at once
  a_clear_drops: assert property (
    $rose(i_clear) && !i_swap_fail_event && !i_conv_alert_enable
    && !i_off_alert_enable |-> ##[2:4] (o_alert_status & 8'h2A) == 8'h00)
    else $error("clear left sticky bits set");
  a_clear_acked: assert property ($rose(i_clear) |-> ##[1:8] o_clear_done)
    else $error("clear never returned");
  a_bit0_quiet: assert property (!i_amp_valid [*4] |-> $stable(o_alert_status[0]))
    else $error("overcurrent bit moved without conversion");
  a_sda_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("SDA drive changed while SCL high");
endmodule : mrs_port_asserts
bind mrs_readback_port mrs_port_asserts u_chk (.i_sys_clk, .i_rst, .i_scl, .o_sda_oe,
  .i_enable_pin, .i_software_off, .i_clear, .i_swap_fail_event, .i_amp_valid,
  .i_conv_alert_enable, .i_off_alert_enable, .o_clear_done, .o_alert_status);

// ### test/mrs_bus_master.sv
/*
  Two-wire bus master model: start, address, data bytes, ack, stop.
  Assumes a pull-up on SDA and the port's two flop input sync.
*/
`timescale 1ns/1ps
module mrs_bus_master (
  input wire logic i_sys_clk,
  input wire logic i_sda_oe,
  output logic o_scl,
  output logic o_sda
);
  logic low_reg = 1'b0;
  logic [23:0] sh_reg = 24'h000000;
  initial o_scl = 1'b1;
  // Open drain with pull-up: high unless someone pulls it down
  assign o_sda = ~(low_reg | i_sda_oe);
  task automatic half();
    repeat (8) @(negedge i_sys_clk);
  endtask : half
  task automatic put(input logic b);
    low_reg = ~b;
    half();
    o_scl = 1'b1;
    half();
    sh_reg = {sh_reg[22:0], o_sda};
    o_scl = 1'b0;
  endtask : put
  task automatic xfer(input logic [7:0] a, input int n, output logic ack, output logic [23:0] d);
    low_reg = 1'b1; // Start: SDA falls while SCL is high
    half();
    o_scl = 1'b0;
    for (int i = 7; i >= 0; i--) put(a[i]); // Address then the read bit
    put(1'b1);
    ack = ~sh_reg[0];
    sh_reg = 24'h000000;
    for (int k = 0; k < n && ack; k++)
    begin
      repeat (8) put(1'b1);
      // A lone status byte is acked; longer frames nack their last byte
      put(k == n - 1 && n > 1);
      sh_reg = sh_reg >> 1;
    end
    d = sh_reg;
    low_reg = 1'b1; // Stop: SDA rises while SCL is high
    half();
    o_scl = 1'b1;
    half();
    low_reg = 1'b0;
    half();
  endtask : xfer
endmodule : mrs_bus_master

// ### test/tb_top.sv
/*
  Bench for the readback port: frames, status flags and clear.
  Assumes the bus master model and the bound checker.
*/
`timescale 1ns/1ps
module tb_top;
  localparam logic [23:0] NO_ACK = 24'hEEEEEE;
  logic i_sys_clk = 1'b0, i_rst = 1'b1, i_scl, i_sda, o_sda_oe, o_clear_done, o_once_done;
  logic i_volt_continuous = 1'b0, i_amp_continuous = 1'b0, i_volt_once = 1'b0, ack;
  logic i_amp_once = 1'b0, i_status_read = 1'b0, i_divider_range_select = 1'b0;
  logic i_volt_valid = 1'b0, i_amp_valid = 1'b0, i_conv_alert_enable = 1'b0, i_clear = 1'b0;
  logic i_analog_trip_off = 1'b0, i_swap_fail_event = 1'b0, i_swap_fail_alert_enable = 1'b1;
  logic i_off_alert_enable = 1'b0, i_enable_pin = 1'b1, i_software_off = 1'b0;
  logic [6:0] i_dev_addr = mrs_pkg::DEV_ADDR_DEFAULT;
  logic [mrs_pkg::DATA_W-1:0] i_volt_code = 12'h000, i_amp_code = 12'h000, v, a;
  logic [7:0] i_amp_threshold = 8'hC0, o_alert_status;
  logic [mrs_pkg::DATA_W+7:0] o_volt_step_uv_x4096;
  logic [23:0] d, exp_q[$], got_q[$];
  logic [63:0] e;
  int n_errors = 0, check_count = 0, seed = 54959;
  initial forever #5 i_sys_clk = ~i_sys_clk;
  mrs_bus_master i_bus (.i_sys_clk, .i_sda_oe(o_sda_oe), .o_scl(i_scl), .o_sda(i_sda));
  mrs_readback_port i_dut (.i_sys_clk, .i_rst, .i_scl, .i_sda, .o_sda_oe, .i_dev_addr,
    .i_volt_continuous, .i_amp_continuous, .i_volt_once, .i_amp_once, .i_status_read,
    .i_divider_range_select, .i_volt_code, .i_volt_valid, .i_amp_code, .i_amp_valid,
    .i_amp_threshold, .i_conv_alert_enable, .i_analog_trip_off, .i_swap_fail_event,
    .i_swap_fail_alert_enable, .i_off_alert_enable, .i_enable_pin, .i_software_off,
    .i_clear, .o_clear_done, .o_once_done, .o_alert_status, .o_volt_step_uv_x4096);
  task automatic cyc(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask : cyc
  task automatic chk(input logic [23:0] ex, input logic [23:0] g);
    exp_q.push_back(ex);
    got_q.push_back(g);
  endtask : chk
  task automatic rd(input logic [6:0] ad, input int n, input logic [23:0] ex);
    exp_q.push_back(ex);
    i_bus.xfer({ad, 1'b1}, n, ack, d);
    got_q.push_back(ack ? d : NO_ACK);
  endtask : rd
  task automatic st(input logic [7:0] ex);
    cyc(4);
    chk({16'h0000, ex}, {16'h0000, o_alert_status});
  endtask : st
  task automatic conv(input logic sel_v, input logic [mrs_pkg::DATA_W-1:0] c);
    {i_volt_valid, i_amp_valid} = {sel_v, !sel_v};
    if (sel_v) i_volt_code = c;
    else i_amp_code = c;
    cyc(1);
    {i_volt_valid, i_amp_valid} = 2'b00;
    cyc(1);
  endtask : conv
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  always @(negedge i_sys_clk)
    while (got_q.size() > 0)
    begin
      check_count++;
      if (got_q[0] !== exp_q[0])
      begin
        n_errors++;
        $display("wrong value at %0t: got %h expected %h", $time, got_q[0], exp_q[0]);
      end
      void'(got_q.pop_front());
      void'(exp_q.pop_front());
    end
  initial
  begin
    cyc(5);
    i_rst = 1'b0;
    cyc(3);
    {i_volt_continuous, i_amp_continuous} = 2'b11;
    rd(i_dev_addr, 3, 24'h000000);
    rd(i_dev_addr ^ 7'h01, 1, NO_ACK);
    $display("test done: empty and misaddressed reads");
    // Amp codes stay below the threshold so no flag sets here
    for (int m = 0; m < 3; m++)
    begin
      {i_volt_continuous, i_amp_continuous} = {m != 2, m != 1};
      i_divider_range_select = m[0];
      v = 12'($random(seed));
      a = 12'($random(seed)) & 12'h7FF;
      conv(1'b1, v);
      conv(1'b0, a);
      e = (64'(v) * (m[0] ? mrs_pkg::VOLT_FS_NARROW_UV : mrs_pkg::VOLT_FS_WIDE_UV)) >> 20;
      chk(e[23:0], 24'(o_volt_step_uv_x4096));
      if (m == 0) rd(i_dev_addr, 3, {v[11:4], a[11:4], v[3:0], a[3:0]});
      else if (m == 1) rd(i_dev_addr, 2, {8'h00, v, 4'h0});
      else rd(i_dev_addr, 2, {8'h00, a, 4'h0});
    end
    $display("test done: frame formats");
    {i_volt_continuous, i_amp_continuous, i_volt_once} = 3'b001;
    cyc(2);
    chk(24'h000000, {23'h0, o_once_done});
    rd(i_dev_addr, 1, NO_ACK);
    v = 12'($random(seed));
    conv(1'b1, v);
    i_volt_once = 1'b0;
    cyc(2);
    chk(24'h000001, {23'h0, o_once_done});
    rd(i_dev_addr, 2, {8'h00, v, 4'h0});
    i_amp_once = 1'b1;
    rd(i_dev_addr, 2, NO_ACK);
    a = 12'($random(seed)) & 12'h7FF;
    conv(1'b0, a);
    rd(i_dev_addr, 2, {8'h00, a, 4'h0});
    i_amp_once = 1'b0;
    $display("test done: single conversion");
    i_status_read = 1'b1;
    st(8'h00);
    i_conv_alert_enable = 1'b1;
    repeat (3) conv(1'b0, 12'hFFF);
    st(8'h03);
    i_swap_fail_event = 1'b1;
    cyc(1);
    i_swap_fail_event = 1'b0;
    // Bit 2 mirrors the latched failure while its alert is enabled
    st(8'h0F);
    rd(i_dev_addr, 1, 24'h00000F);
    {i_off_alert_enable, i_software_off} = 2'b11;
    st(8'h3F);
    i_software_off = 1'b0;
    st(8'h2F);
    {i_conv_alert_enable, i_off_alert_enable, i_clear} = 3'b001;
    for (int i = 0; i < 20 && o_clear_done !== 1'b1; i++) cyc(1);
    if (o_clear_done !== 1'b1)
    begin
      n_errors++;
      $display("wrong value at %0t: clear never returned", $time);
      final_report();
    end
    st(8'h01);
    i_clear = 1'b0;
    i_enable_pin = 1'b0;
    cyc(4);
    st(8'h11);
    i_enable_pin = 1'b1;
    // With the sticky copy disabled bit 2 shows the present trip state
    {i_analog_trip_off, i_swap_fail_alert_enable} = 2'b10;
    cyc(4);
    chk(24'h000001, {23'h0, o_alert_status[2]});
    $display("test done: status flags and clear");
    cyc(2);
    final_report();
  end
endmodule : tb_top
